// >>> core/fns_pkg.sv
// Package for the fractional-N source and configuration select block.
// Assumes a single 25 MHz bus clock that also serves as the timing reference.
package fns_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned REF_LOSS_US   = 40_000;
  localparam int unsigned REF_LOSS_CYC  = REF_LOSS_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_RATIO0     = 8'h00;
  localparam logic [7:0] OFS_RATIO3     = 8'h0c;
  localparam logic [7:0] OFS_MODAL      = 8'h10;
  localparam logic [7:0] OFS_GLOBAL     = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_FRACN      = 8'h1c;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_RATIO     = 32'h0010_0000;
  localparam logic [3:0]  RST_MODAL     = 4'h0;
  localparam logic [1:0]  RST_DIV_CODE  = 2'h2;
  localparam logic [2:0]  RST_BW_CODE   = 3'h0;
  localparam logic        RST_AUTO_SRC  = 1'b0;

  // ==========================================================================
  // Reference divider codes
  localparam logic [1:0] DIV_BY1        = 2'h2;
  localparam logic [1:0] DIV_BY2        = 2'h1;
  localparam logic [1:0] DIV_BY4        = 2'h0;

  // ==========================================================================
  // Digital loop
  localparam int unsigned FRAC_BITS     = 20;
  localparam logic [3:0]  ACQ_SHIFT     = 4'h1;
  localparam logic [3:0]  BW_SHIFT_MAX  = 4'ha;
  localparam logic [2:0]  LOCK_RUN      = 3'h7;
  localparam logic [33:0] LOCK_TOL      = 34'h0_0010_0000;
  localparam logic [33:0] UNLOCK_TOL    = 34'h0_0040_0000;

  typedef struct packed {
    logic       auto_src;
    logic [2:0] bw_code;
    logic [1:0] div_code;
  } fns_glob_cfg_s;

  typedef enum logic {DPLL_ACQUIRE, DPLL_LOCKED} fns_dpll_e;

endpackage

// >>> core/fns_fracn_select.sv
// Fractional-N source select, modal set select and digital loop, AHB-Lite slave.
// Assumes hclk is the timing reference and that mode pins, the frequency
// reference and the synthesizer feedback arrive asynchronously.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps

// How it works
// RULE_01: Synthesizer value is either the stored static ratio or the loop's dynamic ratio.
// RULE_02: Hybrid chosen by frequency reference presence in auto mode, else by modal bit.
// RULE_03: Four stored sets; two-bit select pin value is the index of the applied set.
// RULE_04: Global settings live in one register the select pins never touch.
// RULE_05: Timing tick is the reference divided by 1, 2 or 4 per divider code.
// RULE_06: Software picks the divider code so the divided clock stays within 8-14 MHz.
// RULE_07: Code 10 divides by one, 01 by two, 00 by four.
// RULE_08: Frequency reference drives the loop only while in hybrid mode.
// RULE_09: Loop counts synthesizer edges per reference period to form the ratio error.
// RULE_10: Loop integrator holds the value referred to the divided timing clock.
// RULE_11: Three-bit bandwidth code sets the loop's minimum bandwidth floor.
// RULE_12: First-order loop passes jitter below its corner straight through.
// RULE_13: Wide bandwidth while acquiring, bandwidth floor once locked.
// RULE_14: Select pins are synchronised and applied only on a divided timing tick.
module fns_fracn_select #(
  parameter int unsigned REF_LOSS_CYCLES = fns_pkg::REF_LOSS_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        freq_ref_in,
  input  wire logic        synth_out_in,
  output logic      [31:0] fracn_value,
  output logic             divided_timing_tick,
  output logic             hybrid_mode,
  output logic             dpll_locked
);

  // ==========================================================================
  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [2:0] sync_q [4];
  logic [3:0] pin_raw;
  logic [3:0] pin_stable;

  assign pin_raw = {synth_out_in, freq_ref_in, mode_sel};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_q[g]     <= 3'h0;
        pin_stable[g] <= 1'b0;
      end else begin
        sync_q[g] <= {sync_q[g][1:0], pin_raw[g]};
        if (sync_q[g][1] == sync_q[g][2]) begin
          pin_stable[g] <= sync_q[g][2];
        end
      end
    end
  end

  logic [1:0] mode_stable;
  logic       ref_q;
  logic       synth_q;
  logic       ref_rise;
  logic       synth_rise;

  assign mode_stable = pin_stable[1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q   <= 1'b0;
      synth_q <= 1'b0;
    end else begin
      ref_q   <= pin_stable[2];
      synth_q <= pin_stable[3];
    end
  end

  assign ref_rise   = pin_stable[2] && !ref_q;
  assign synth_rise = pin_stable[3] && !synth_q;

  // ==========================================================================
  // AHB-Lite slave, zero wait states, reads registered in the address phase
  logic [31:0]           ratio [4];
  logic [3:0]            modal_src;
  fns_pkg::fns_glob_cfg_s glob_cfg;
  logic                  wr_pend;
  logic [7:0]            wr_addr;
  logic                  addr_ok;
  logic [31:0]           next_rdata;
  logic [5:0]            status;
  fns_pkg::fns_dpll_e    dpll_state;
  logic                  ref_present;
  logic [1:0]            active_set;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;
  assign status    = {glob_cfg.div_code != 2'h3, ref_present, dpll_state == fns_pkg::DPLL_LOCKED,
                      hybrid_mode, active_set};

  always_comb begin
    next_rdata = 32'h0;
    if (haddr[7:0] <= fns_pkg::OFS_RATIO3 && haddr[31:8] == 24'h0) begin
      next_rdata = ratio[haddr[3:2]];
    end else if (haddr[31:8] == 24'h0) begin
      unique case (haddr[7:0])
        fns_pkg::OFS_MODAL:  next_rdata = {28'h0, modal_src};
        fns_pkg::OFS_GLOBAL: next_rdata = {26'h0, glob_cfg};
        fns_pkg::OFS_STATUS: next_rdata = {26'h0, status};
        fns_pkg::OFS_FRACN:  next_rdata = fracn_value;
        default:             next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata  <= 32'h0;
    end else begin
      wr_pend <= addr_ok && hwrite && haddr[31:8] == 24'h0;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= next_rdata;
        end
      end
    end
  end

  // Stored sets and global settings; nothing but a bus write changes them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        ratio[i] <= fns_pkg::RST_RATIO;
      end
      modal_src <= fns_pkg::RST_MODAL;
      glob_cfg  <= '{fns_pkg::RST_AUTO_SRC, fns_pkg::RST_BW_CODE, fns_pkg::RST_DIV_CODE};
    end else if (wr_pend) begin
      if (wr_addr <= fns_pkg::OFS_RATIO3) begin
        ratio[wr_addr[3:2]] <= hwdata; // RULE_03
      end else if (wr_addr == fns_pkg::OFS_MODAL) begin
        modal_src <= hwdata[3:0];
      end else if (wr_addr == fns_pkg::OFS_GLOBAL) begin
        glob_cfg <= hwdata[5:0]; // RULE_04 RULE_11
      end
    end
  end

  // ==========================================================================
  // Reference divider; code 11 is not a valid setting and divides by four
  logic [1:0] div_cnt;
  logic [1:0] div_mask;
  logic [1:0] div_shift;

  always_comb begin
    unique case (glob_cfg.div_code)
      fns_pkg::DIV_BY1: begin div_mask = 2'h0; div_shift = 2'h0; end // RULE_07
      fns_pkg::DIV_BY2: begin div_mask = 2'h1; div_shift = 2'h1; end // RULE_07
      default:          begin div_mask = 2'h3; div_shift = 2'h2; end // RULE_07
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // Range of the divided clock is up to the code software writes
  assign divided_timing_tick = (div_cnt & div_mask) == 2'h0; // RULE_05 RULE_06

  // Set switches only on a tick so the ratio and source change together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_set <= 2'h0;
    end else if (divided_timing_tick) begin
      active_set <= mode_stable; // RULE_14 RULE_03
    end
  end

  // ==========================================================================
  // Reference presence and source choice
  logic [31:0] loss_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loss_cnt    <= 32'h0;
      ref_present <= 1'b0;
    end else if (ref_rise) begin
      loss_cnt    <= 32'h0;
      ref_present <= 1'b1;
    end else if (loss_cnt >= REF_LOSS_CYCLES[31:0]) begin
      ref_present <= 1'b0;
    end else begin
      loss_cnt <= loss_cnt + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hybrid_mode <= 1'b0;
    end else begin
      hybrid_mode <= glob_cfg.auto_src ? ref_present : modal_src[active_set]; // RULE_02
    end
  end

  // ==========================================================================
  // Digital loop: one update per reference period
  logic [11:0]        synth_cnt;
  logic [31:0]        n_dyn;
  logic [31:0]        static_n;
  logic signed [33:0] err;
  logic [33:0]        err_abs;
  logic [3:0]         loop_shift;
  logic signed [33:0] next_sum;
  logic [2:0]         lock_run;
  logic               cnt_valid;

  assign static_n = ratio[active_set] << div_shift;
  assign err      = $signed({2'b00, ratio[active_set]})
                  - $signed({2'b00, synth_cnt, 20'h0}); // RULE_09
  assign err_abs  = err[33] ? 34'(-err) : 34'(err);
  assign loop_shift = (dpll_state == fns_pkg::DPLL_ACQUIRE) ? fns_pkg::ACQ_SHIFT
                    : fns_pkg::BW_SHIFT_MAX - {1'b0, glob_cfg.bw_code}; // RULE_13 RULE_11
  assign next_sum = $signed({2'b00, n_dyn}) + (err >>> loop_shift); // RULE_12

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synth_cnt <= 12'h0;
      cnt_valid <= 1'b0;
    end else if (!hybrid_mode || ref_rise) begin
      synth_cnt <= 12'h0;
      cnt_valid <= hybrid_mode; // RULE_09
    end else if (synth_rise && synth_cnt != 12'hfff) begin
      synth_cnt <= synth_cnt + 12'h1;
    end
  end

  // Seeded from the static value; the partial period at hybrid entry is never measured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_dyn <= fns_pkg::RST_RATIO;
    end else if (!hybrid_mode) begin
      n_dyn <= static_n; // RULE_08
    end else if (ref_rise && cnt_valid) begin
      n_dyn <= next_sum[33] ? 32'h0 : next_sum[31:0]; // RULE_10
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dpll_state <= fns_pkg::DPLL_ACQUIRE;
      lock_run   <= 3'h0;
    end else if (!hybrid_mode) begin
      dpll_state <= fns_pkg::DPLL_ACQUIRE;
      lock_run   <= 3'h0;
    end else if (ref_rise && cnt_valid) begin
      unique case (dpll_state)
        fns_pkg::DPLL_ACQUIRE: begin
          if (err_abs >= fns_pkg::LOCK_TOL) begin
            lock_run <= 3'h0;
          end else if (lock_run == fns_pkg::LOCK_RUN) begin
            dpll_state <= fns_pkg::DPLL_LOCKED; // RULE_13
          end else begin
            lock_run <= lock_run + 3'h1;
          end
        end
        fns_pkg::DPLL_LOCKED: begin
          if (err_abs >= fns_pkg::UNLOCK_TOL) begin
            dpll_state <= fns_pkg::DPLL_ACQUIRE;
            lock_run   <= 3'h0;
          end
        end
      endcase
    end
  end

  assign dpll_locked = dpll_state == fns_pkg::DPLL_LOCKED;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fracn_value <= fns_pkg::RST_RATIO;
    end else begin
      fracn_value <= hybrid_mode ? n_dyn : static_n; // RULE_01
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_lock_entry;
    dpll_state == fns_pkg::DPLL_ACQUIRE && lock_run == fns_pkg::LOCK_RUN && ref_rise
      && hybrid_mode && err_abs < fns_pkg::LOCK_TOL;
  endsequence

  a_source_static_out: assert property (!hybrid_mode ##1 !hybrid_mode // RULE_01
      |-> fracn_value == $past(static_n)) else $error("static ratio not forwarded");
  a_source_auto_pick: assert property (glob_cfg.auto_src && $stable(glob_cfg) // RULE_02
      |=> hybrid_mode == $past(ref_present)) else $error("auto source wrong");
  a_source_manual_pick: assert property (!glob_cfg.auto_src && $stable(glob_cfg) // RULE_02
      |=> hybrid_mode == $past(modal_src[active_set])) else $error("manual source wrong");
  a_set_follows_pins: assert property (divided_timing_tick // RULE_03 RULE_14
      |=> active_set == $past(mode_stable)) else $error("set index not applied");
  a_global_pin_proof: assert property (!wr_pend // RULE_04
      |=> $stable(glob_cfg)) else $error("global settings moved");
  a_tick_div_four: assert property (glob_cfg.div_code == fns_pkg::DIV_BY4 [*5] ##0 // RULE_05
      divided_timing_tick |-> ##0 1 ##4 divided_timing_tick) else $error("tick spacing");
  a_tick_div4_gap: assert property ($past(glob_cfg.div_code, 4) == fns_pkg::DIV_BY4 // RULE_07
      && $stable(glob_cfg.div_code) && glob_cfg.div_code == fns_pkg::DIV_BY4
      && divided_timing_tick |-> !$past(divided_timing_tick)) else $error("extra tick");
  a_loop_idle_static: assert property (!hybrid_mode // RULE_08
      |=> dpll_state == fns_pkg::DPLL_ACQUIRE && n_dyn == $past(static_n))
      else $error("loop ran outside hybrid");
  a_lock_after_run: assert property (s_lock_entry // RULE_13
      |=> dpll_locked) else $error("lock not taken");
  a_bw_floor_locked: assert property (dpll_locked // RULE_11
      |-> loop_shift == 4'ha - {1'b0, glob_cfg.bw_code}) else $error("bandwidth floor");
  a_bw_wide_acquire: assert property (!dpll_locked // RULE_13
      |-> loop_shift == 4'h1) else $error("acquire bandwidth");
  a_ratio_update: assert property (hybrid_mode && cnt_valid && ref_rise // RULE_09 RULE_10 RULE_12
      && $past(hybrid_mode) |=> n_dyn == ($past(next_sum[33]) ? 32'h0 : $past(next_sum[31:0])))
      else $error("integrator update");
  a_partial_skip: assert property (hybrid_mode && !cnt_valid && ref_rise // RULE_09
      |=> $stable(n_dyn)) else $error("partial period measured");

endmodule // fns_fracn_select

// >>> bench/fns_clk_src.sv
// Far-side model: frequency reference source and synthesizer output feedback.
// Assumes the bench enables each clock; both run on their own time base.
`timescale 1ns/100ps

module fns_clk_src #(
  parameter int REF_HALF_NS   = 1280,
  parameter int SYNTH_HALF_NS = 320
) (
  input  wire logic ref_on,
  input  wire logic synth_on,
  output logic      freq_ref_in,
  output logic      synth_out_in
);
  // ==========================================================================
  // Clock generators
  // A stopped source stands low; the odd start offsets keep edges off hclk edges
  initial begin
    freq_ref_in = 1'b0;
    #7;
    forever begin
      #(REF_HALF_NS) freq_ref_in = ref_on ? ~freq_ref_in : 1'b0;
    end
  end

  // Synth edges sit well away from reference edges so each period counts alike
  initial begin
    synth_out_in = 1'b0;
    #167;
    forever begin
      #(SYNTH_HALF_NS) synth_out_in = synth_on ? ~synth_out_in : 1'b0;
    end
  end
endmodule // fns_clk_src

// >>> bench/test_fracn_source_and_config_select.sv
// Testbench for the fractional-N source and configuration select block.
// Assumes one 25 MHz clock, AHB-Lite register access and the far-side clock model.
`timescale 1ns/100ps

module test_fracn_source_and_config_select;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  mode_sel;
  logic        freq_ref_in;
  logic        synth_out_in;
  logic [31:0] fracn_value;
  logic        divided_timing_tick;
  logic        hybrid_mode;
  logic        dpll_locked;
  logic        ref_on;
  logic        synth_on;
  logic [31:0] rd;
  logic [31:0] v0;
  int          mismatches;
  int          samples_checked;
  int          k;
  int          n;

  fns_fracn_select #(.REF_LOSS_CYCLES(200)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_sel(mode_sel),
    .freq_ref_in(freq_ref_in), .synth_out_in(synth_out_in), .fracn_value(fracn_value),
    .divided_timing_tick(divided_timing_tick), .hybrid_mode(hybrid_mode),
    .dpll_locked(dpll_locked));

  fns_clk_src src_u (.ref_on(ref_on), .synth_on(synth_on),
    .freq_ref_in(freq_ref_in), .synth_out_in(synth_out_in));

  // ==========================================================================
  // Clock, watchdog and shared tasks
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h2, "bus response");
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic ticks(input int exp);
    n = 0;
    repeat (8) begin
      @(posedge hclk);
      #1 n += int'(divided_timing_tick);
    end
    chk(n, exp, "ticks per 8 cycles");
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; mode_sel = 2'h0; ref_on = 1'b0; synth_on = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    cyc(10);
    hresetn <= 1'b1;
    chk(fracn_value, 32'h0010_0000, "fracn after reset");
    chk({31'h0, hybrid_mode}, 32'h0, "hybrid after reset");
    for (k = 0; k < 4; k++) rd_chk(32'(k * 4), 32'h0010_0000, "ratio reset");
    rd_chk(32'h14, 32'h0000_0002, "global reset");
    rd_chk(32'h20, 32'h0, "unmapped read");
    bus(1'b1, 32'h20, 32'hffff_ffff);
    rd_chk(32'h20, 32'h0, "unmapped after write");
    for (k = 0; k < 4; k++) bus(1'b1, 32'(k * 4), 32'h0010_0000 * (k + 1));
    bus(1'b1, 32'h10, 32'h8);
    bus(1'b1, 32'h14, 32'h0000_0016);
    // Each pin value applies its own set; pins never move global settings
    for (k = 3; k >= 0; k--) begin
      mode_sel <= 2'(k);
      cyc(2);
      chk(fracn_value, 32'h0010_0000 * ((k + 1) % 4 + 1), "set before sync");
      cyc(8);
      chk(fracn_value, 32'h0010_0000 * (k + 1), "fracn of set");
      chk({31'h0, hybrid_mode}, {31'h0, k == 3}, "modal source bit");
      rd_chk(32'h14, 32'h0000_0016, "global under pin change");
    end
    // Divider codes 10, 01, 00 and the illegal 11 on set 1 (ratio 2.0)
    mode_sel <= 2'h1;
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 32'h14, {30'h0, 2'(2 - k)} & 32'h3);
      cyc(6);
      v0 = (k == 3) ? 32'h0080_0000 : 32'h0020_0000 << k;
      chk(fracn_value, v0, "static fracn per divider");
      ticks(k == 3 ? 2 : 8 >> k);
      rd_chk(32'h18, {26'h0, k != 3, 3'h0, 2'h1}, "status divider legal");
    end
    // Manual hybrid on set 3: ratio 4.0, synth runs four times the reference
    bus(1'b1, 32'h14, 32'h0000_000e);
    ref_on   <= 1'b1;
    synth_on <= 1'b1;
    mode_sel <= 2'h3;
    for (k = 0; k < 3000 && dpll_locked !== 1'b1; k++) @(posedge hclk);
    chk({31'h0, dpll_locked}, 32'h1, "loop locks");
    chk(fracn_value, 32'h0040_0000, "dynamic fracn on ratio");
    rd_chk(32'h18, 32'h0000_003f, "status hybrid locked");
    rd_chk(32'h1c, 32'h0040_0000, "fracn readback");
    synth_on <= 1'b0;
    v0 = fracn_value;
    for (k = 0; k < 400 && dpll_locked !== 1'b0; k++) @(posedge hclk);
    chk({31'h0, dpll_locked}, 32'h0, "unlock on lost synth");
    cyc(300);
    chk({31'h0, fracn_value > v0}, 32'h1, "loop pushes ratio up");
    mode_sel <= 2'h2;
    cyc(12);
    chk({31'h0, hybrid_mode}, 32'h0, "leave hybrid by pins");
    chk(fracn_value, 32'h0030_0000, "static value restored");
    // Automatic source selection follows the reference presence
    bus(1'b1, 32'h14, 32'h0000_002e);
    for (k = 0; k < 200 && hybrid_mode !== 1'b1; k++) @(posedge hclk);
    chk({31'h0, hybrid_mode}, 32'h1, "auto hybrid with reference");
    ref_on <= 1'b0;
    cyc(100);
    chk({31'h0, hybrid_mode}, 32'h1, "hybrid before loss time");
    for (k = 0; k < 400 && hybrid_mode !== 1'b0; k++) @(posedge hclk);
    chk({31'h0, hybrid_mode}, 32'h0, "static after reference loss");
    cyc(4);
    chk(fracn_value, 32'h0030_0000, "static fracn in auto");
    rd_chk(32'h14, 32'h0000_002e, "global holds bandwidth code");
    test_done();
  end
endmodule // test_fracn_source_and_config_select
